// ### hw/etco_timer.sv
// Enhanced timer slice: 10-bit counter, compare A/B, period bits, two outputs,
// channel B capture input, registers behind an AXI4-Lite slave.
// Assumes the counter ticks on every ref_clk edge; clock selection lies elsewhere.
//
// Operation
// - Channel B mode field: compare, capture, PWM or pulse, timer.
// - Compare mode match: hold, drive low, drive high or toggle channel B pin.
// - PWM mode: force inactive, force active, PWM waveform or single pulse.
// - Capture on rising, falling or both edges; code three disables capture.
// - Match changes pin only if requested level differs from initial level.
// - Counter-on rising edge returns compare outputs to their initial level.
// - Level bit sets initial level in compare, active level in PWM.
// - Invert bit inverts channel B pin; unused in timer mode.
// - Alignment field: edge, or centre matching up, down or both.
// - Counter readable only, low byte and two high bits, rest zero.
// - Compare A value in low byte and two high bits, reset zero.
// - Compare B value in low byte and two high bits, reset zero.
// - Clear source low: period match or overflow clears; A and P flags.
// - Clear source high: compare A clears counter; no period flag.
// - Only compare A or B matches move pins; period match never.
// - Channel B pin follows compare B, channel A pin compare A.
// - Period bits meet counter top bits; zero lets counter overflow.
// - Counter-on rise zeroes counter; fall stops and holds count.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module etco_timer
  import etco_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Timer pins
  input wire logic chanBCapturePin,
  output logic chanAOutPin,
  output logic chanBOutPin
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : gAddrCheck
    $error("ADDR_WIDTH must lie between 8 and 32");
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic addrKnown(input logic [7:0] addr);
    case (addr)
      OFF_CTRL0, OFF_CTRL1, OFF_CTRL2, OFF_CNT_LO, OFF_CNT_HI,
      OFF_CMPA_LO, OFF_CMPA_HI, OFF_CMPB_LO, OFF_CMPB_HI, OFF_FLAGS: addrKnown = 1'b1;
      default: addrKnown = 1'b0;
    endcase
  endfunction : addrKnown

  function automatic logic [DATA_W-1:0] readReg(input logic [7:0] addr,
                                                input etco_timer_state_type s);
    logic [7:0] b;
    b = 8'h00;
    case (addr)
      OFF_CTRL0: b = s.ctrl0;
      OFF_CTRL1: b = s.ctrl1;
      OFF_CTRL2: b = s.ctrl2;
      OFF_CNT_LO: b = s.cnt[7:0];
      OFF_CNT_HI: b = {6'h00, s.cnt[9:8]};
      OFF_CMPA_LO: b = s.compareA[7:0];
      OFF_CMPA_HI: b = {6'h00, s.compareA[9:8]};
      OFF_CMPB_LO: b = s.compareB[7:0];
      OFF_CMPB_HI: b = {6'h00, s.compareB[9:8]};
      OFF_FLAGS: b = {5'h00, s.flags};
      default: b = 8'h00;
    endcase
    readReg = {24'h000000, b};
  endfunction : readReg

  function automatic logic captureHit(input logic [1:0] func, input logic rise,
                                      input logic fall);
    case (func)
      CAP_RISE: captureHit = rise;
      CAP_FALL: captureHit = fall;
      CAP_BOTH: captureHit = rise | fall;
      default: captureHit = 1'b0;
    endcase
  endfunction : captureHit

  // ----------------------------------------------------------------------
  // State and decoded conditions
  // ----------------------------------------------------------------------
  etco_timer_state_type st_q;
  etco_timer_state_type st_d;

  logic counterRise;
  logic running;
  logic modeACapture;
  logic modeBCapture;
  logic pwmMode;
  logic singlePulse;
  logic centre;
  logic eqA;
  logic eqB;
  logic periodEq;
  logic [CNT_W-1:0] periodTop;
  logic [CNT_W-1:0] centreTop;
  logic dirOk;
  logic hitA;
  logic hitB;
  logic hitP;
  logic clearOnA;
  logic clearOnP;
  logic capHit;
  logic writeFire;
  etco_chan_cfg_type cfgA;
  etco_chan_cfg_type cfgB;

  assign counterRise = st_q.ctrl0.counterOn & ~st_q.onPrev;
  assign running = st_q.ctrl0.counterOn & ~st_q.ctrl0.pause & ~counterRise;
  assign modeACapture = st_q.ctrl1.modeSel == MODE_CAPTURE;
  assign modeBCapture = st_q.ctrl2.modeSel == MODE_CAPTURE;
  assign pwmMode = st_q.ctrl1.modeSel == MODE_PWM;
  assign singlePulse = pwmMode && st_q.ctrl1.pinFunc == FUNC_PULSE;
  assign centre = pwmMode && !singlePulse && st_q.ctrl2.pwmAlignSel != ALIGN_EDGE;
  assign eqA = st_q.cnt == st_q.compareA;
  assign eqB = st_q.cnt == st_q.compareB;
  assign periodTop = {st_q.ctrl0.periodBits, {PERIOD_LSB{1'b0}}};
  assign periodEq = (st_q.ctrl0.periodBits == '0) ? (st_q.cnt == '1)
                                                   : (st_q.cnt == periodTop);
  assign centreTop = st_q.ctrl1.clearSourceSel ? st_q.compareA
                   : ((st_q.ctrl0.periodBits == '0) ? '1 : periodTop);
  always_comb begin
    case (st_q.ctrl2.pwmAlignSel)
      ALIGN_UP: dirOk = !centre || !st_q.ctrl1.countDown;
      ALIGN_DOWN: dirOk = !centre || st_q.ctrl1.countDown;
      default: dirOk = 1'b1;
    endcase
  end
  assign hitA = running && eqA && dirOk && !modeACapture;
  assign hitB = running && eqB && dirOk && !modeBCapture;
  assign clearOnA = st_q.ctrl1.clearSourceSel && !singlePulse && !modeACapture;
  assign clearOnP = !st_q.ctrl1.clearSourceSel && !singlePulse && !modeACapture;
  assign hitP = running && clearOnP
             && (centre ? (st_q.ctrl1.countDown && st_q.cnt == '0) : periodEq);
  assign capHit = modeBCapture
               && captureHit(st_q.ctrl2.pinFunc, st_q.capSync2 & ~st_q.capPrev,
                             ~st_q.capSync2 & st_q.capPrev);
  assign writeFire = st_q.axi.awHave && st_q.axi.wHave && !st_q.axi.bValid;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Capture pin synchroniser
    st_d.capSync1 = chanBCapturePin;
    st_d.capSync2 = st_q.capSync1;
    st_d.capPrev = st_q.capSync2;
    st_d.onPrev = st_q.ctrl0.counterOn;

    // Bus channel acceptance
    if (awvalid && awready) begin
      st_d.axi.awHave = 1'b1;
      st_d.axi.awAddr = awaddr[7:0];
    end
    if (wvalid && wready) begin
      st_d.axi.wHave = 1'b1;
      st_d.axi.wData = wdata[7:0];
      st_d.axi.wStrb0 = wstrb[0];
    end
    if (st_q.axi.bValid && bready) begin
      st_d.axi.bValid = 1'b0;
    end

    // Register write, applied before hardware events so that sets win
    if (writeFire) begin
      st_d.axi.awHave = 1'b0;
      st_d.axi.wHave = 1'b0;
      st_d.axi.bValid = 1'b1;
      st_d.axi.bResp = addrKnown(st_q.axi.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (st_q.axi.wStrb0) begin
        case (st_q.axi.awAddr)
          OFF_CTRL0: st_d.ctrl0 = etco_ctrl0_type'(st_q.axi.wData);
          OFF_CTRL1: begin
            st_d.ctrl1 = etco_ctrl1_type'(st_q.axi.wData);
            st_d.ctrl1.countDown = st_q.ctrl1.countDown;
          end
          OFF_CTRL2: st_d.ctrl2 = etco_ctrl2_type'(st_q.axi.wData);
          OFF_CMPA_LO: st_d.compareA[7:0] = st_q.axi.wData;
          OFF_CMPA_HI: st_d.compareA[9:8] = st_q.axi.wData[1:0];
          OFF_CMPB_LO: st_d.compareB[7:0] = st_q.axi.wData;
          OFF_CMPB_HI: st_d.compareB[9:8] = st_q.axi.wData[1:0];
          OFF_FLAGS: st_d.flags = st_q.flags & ~etco_flags_type'(st_q.axi.wData[2:0]);
          default: st_d.ctrl0 = st_d.ctrl0;
        endcase
      end
    end

    // Register read
    if (st_q.axi.rValid && rready) begin
      st_d.axi.rValid = 1'b0;
    end
    if (arvalid && arready) begin
      st_d.axi.rValid = 1'b1;
      st_d.axi.rData = readReg(araddr[7:0], st_q);
      st_d.axi.rResp = addrKnown(araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
    end

    // Counter
    if (counterRise) begin
      st_d.cnt = '0;
      st_d.ctrl1.countDown = 1'b0;
    end else if (running) begin
      if (centre) begin
        if (!st_q.ctrl1.countDown) begin
          if (st_q.cnt >= centreTop) begin
            st_d.ctrl1.countDown = 1'b1;
            st_d.cnt = st_q.cnt - 10'h001;
          end else begin
            st_d.cnt = st_q.cnt + 10'h001;
          end
        end else if (st_q.cnt == '0) begin
          st_d.ctrl1.countDown = 1'b0;
          st_d.cnt = st_q.cnt + 10'h001;
        end else begin
          st_d.cnt = st_q.cnt - 10'h001;
        end
      end else if ((clearOnA && eqA) || (clearOnP && periodEq)) begin
        st_d.cnt = '0;
      end else begin
        st_d.cnt = st_q.cnt + 10'h001;
      end
    end

    // Single pulse: compare A ends the run, compare B starts the B pulse
    if (singlePulse && hitA) begin
      st_d.ctrl0.counterOn = 1'b0;
    end
    if (!st_q.ctrl0.counterOn) begin
      st_d.pulseB = 1'b0;
    end else if (hitB) begin
      st_d.pulseB = 1'b1;
    end

    // Match and capture flags, sticky
    if (hitA) begin
      st_d.flags.compareA = 1'b1;
    end
    if (hitB) begin
      st_d.flags.compareB = 1'b1;
    end
    if (hitP) begin
      st_d.flags.periodMatch = 1'b1;
    end
    if (capHit) begin
      st_d.compareB = st_q.cnt;
      st_d.flags.compareB = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.ctrl0 <= etco_ctrl0_type'(CTRL0_RST);
      st_q.ctrl1 <= etco_ctrl1_type'(CTRL1_RST);
      st_q.ctrl2 <= etco_ctrl2_type'(CTRL2_RST);
      st_q.cnt <= CNT_RST;
      st_q.compareA <= CMP_RST;
      st_q.compareB <= CMP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------------
  assign awready = !st_q.axi.awHave && !st_q.axi.bValid;
  assign wready = !st_q.axi.wHave && !st_q.axi.bValid;
  assign bvalid = st_q.axi.bValid;
  assign bresp = st_q.axi.bResp;
  assign arready = !st_q.axi.rValid;
  assign rvalid = st_q.axi.rValid;
  assign rdata = st_q.axi.rData;
  assign rresp = st_q.axi.rResp;

  // ----------------------------------------------------------------------
  // Output channels
  // ----------------------------------------------------------------------
  assign cfgA = {st_q.ctrl1.modeSel, st_q.ctrl1.pinFunc, st_q.ctrl1.levelCtrl,
                 st_q.ctrl1.invert};
  assign cfgB = {st_q.ctrl2.modeSel, st_q.ctrl2.pinFunc, st_q.ctrl2.levelCtrl,
                 st_q.ctrl2.invert};

  etco_channel_out uChanA (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cfg(cfgA),
    .match(hitA),
    .restart(counterRise),
    .pwmActive(st_q.cnt < st_q.compareA),
    .pulseActive(st_q.ctrl0.counterOn),
    .pinOut(chanAOutPin)
  );

  etco_channel_out uChanB (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cfg(cfgB),
    .match(hitB),
    .restart(counterRise),
    .pwmActive(st_q.cnt < st_q.compareB),
    .pulseActive(st_q.pulseB),
    .pinOut(chanBOutPin)
  );

endmodule : etco_timer

// ### hw/etco_pkg.sv
// Shared constants, register layouts and state types of the enhanced timer slice.
// Assumes a 10-bit counter ticking on every ref_clk edge and byte-wide registers
// that sit in the low byte of 32-bit AXI4-Lite words.
package etco_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam int DATA_W = 32;
  localparam int PERIOD_W = 3;
  localparam int PERIOD_LSB = 7;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_CNT_LO = 8'h0c;
  localparam logic [7:0] OFF_CNT_HI = 8'h10;
  localparam logic [7:0] OFF_CMPA_LO = 8'h14;
  localparam logic [7:0] OFF_CMPA_HI = 8'h18;
  localparam logic [7:0] OFF_CMPB_LO = 8'h1c;
  localparam logic [7:0] OFF_CMPB_HI = 8'h20;
  localparam logic [7:0] OFF_FLAGS = 8'h24;

  // ----------------------------------------------------------------------
  // Reset values and flag positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_B_BIT = 1;
  localparam int FLAG_P_BIT = 2;

  // ----------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] FUNC_HOLD = 2'h0;
  localparam logic [1:0] FUNC_LOW = 2'h1;
  localparam logic [1:0] FUNC_HIGH = 2'h2;
  localparam logic [1:0] FUNC_TOGGLE = 2'h3;
  localparam logic [1:0] FUNC_INACTIVE = 2'h0;
  localparam logic [1:0] FUNC_ACTIVE = 2'h1;
  localparam logic [1:0] FUNC_PWM = 2'h2;
  localparam logic [1:0] FUNC_PULSE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] ALIGN_EDGE = 2'h0;
  localparam logic [1:0] ALIGN_UP = 2'h1;
  localparam logic [1:0] ALIGN_DOWN = 2'h2;
  localparam logic [1:0] ALIGN_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic pause;
    logic [2:0] clkSel;
    logic counterOn;
    logic [PERIOD_W-1:0] periodBits;
  } etco_ctrl0_type;

  typedef struct packed {
    logic [1:0] modeSel;
    logic [1:0] pinFunc;
    logic levelCtrl;
    logic invert;
    logic countDown;
    logic clearSourceSel;
  } etco_ctrl1_type;

  typedef struct packed {
    logic [1:0] modeSel;
    logic [1:0] pinFunc;
    logic levelCtrl;
    logic invert;
    logic [1:0] pwmAlignSel;
  } etco_ctrl2_type;

  typedef struct packed {
    logic [1:0] modeSel;
    logic [1:0] pinFunc;
    logic levelCtrl;
    logic invert;
  } etco_chan_cfg_type;

  typedef struct packed {
    logic periodMatch;
    logic compareB;
    logic compareA;
  } etco_flags_type;

  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [7:0] wData;
    logic wStrb0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
  } etco_axi_state_type;

  typedef struct packed {
    etco_axi_state_type axi;
    etco_ctrl0_type ctrl0;
    etco_ctrl1_type ctrl1;
    etco_ctrl2_type ctrl2;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] compareA;
    logic [CNT_W-1:0] compareB;
    etco_flags_type flags;
    logic onPrev;
    logic pulseB;
    logic capSync1;
    logic capSync2;
    logic capPrev;
  } etco_timer_state_type;

  typedef struct packed {
    logic level;
    logic pin;
  } etco_chan_state_type;

endpackage : etco_pkg

// ### hw/etco_channel_out.sv
// One timer output channel: compare actions, PWM and pulse levels, polarity.
// Assumes match and restart are one-cycle pulses from the timer core on ref_clk.
`timescale 1ns/1ns
module etco_channel_out
  import etco_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration and events
  input wire etco_chan_cfg_type cfg,
  input wire logic match,
  input wire logic restart,
  input wire logic pwmActive,
  input wire logic pulseActive,
  // Pin
  output logic pinOut
);

  etco_chan_state_type st_q;
  etco_chan_state_type st_d;
  logic activeLevel;

  always_comb begin
    st_d = st_q;
    activeLevel = cfg.levelCtrl;
    case (cfg.modeSel)
      MODE_COMPARE: begin
        if (restart) begin
          st_d.level = cfg.levelCtrl;
        end else if (match) begin
          case (cfg.pinFunc)
            FUNC_LOW: st_d.level = 1'b0;
            FUNC_HIGH: st_d.level = 1'b1;
            FUNC_TOGGLE: st_d.level = ~st_q.level;
            default: st_d.level = st_q.level;
          endcase
        end
      end
      MODE_PWM: begin
        case (cfg.pinFunc)
          FUNC_INACTIVE: st_d.level = ~activeLevel;
          FUNC_ACTIVE: st_d.level = activeLevel;
          FUNC_PWM: st_d.level = pwmActive ? activeLevel : ~activeLevel;
          default: st_d.level = pulseActive ? activeLevel : ~activeLevel;
        endcase
      end
      default: st_d.level = st_q.level;
    endcase
    if (cfg.modeSel == MODE_COMPARE || cfg.modeSel == MODE_PWM) begin
      st_d.pin = st_d.level ^ cfg.invert;
    end else begin
      st_d.pin = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pinOut = st_q.pin;

endmodule : etco_channel_out

// ### dv/etco_timer_sva.sv
// Bus handshake checker for etco_timer, bound to the top module.
// Assumes one ref_clk domain and the active-low asynchronous rst_n.
`timescale 1ns/1ns
module etco_timer_sva
  import etco_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [DATA_W-1:0] rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wr_answer;
    !bvalid ##1 bvalid;
  endsequence
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write answer timing wrong");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_resp_codes: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
    else $error("illegal write response");
endmodule : etco_timer_sva

bind etco_timer etco_timer_sva u_etco_timer_sva (.ref_clk(ref_clk), .rst_n(rst_n),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata));

// ### dv/etco_pin_model.sv
// Far-side pin model: drives the capture input, counts output B moves.
// Assumes set_capture is called just after a rising ref_clk edge.
`timescale 1ns/1ns
module etco_pin_model (
  // Timer pins
  output logic chanBCapturePin,
  input wire logic chanBOutPin,
  // Observation
  output int bChanges
);
  initial chanBCapturePin = 1'b0;
  initial bChanges = 0;
  task automatic set_capture(input logic v);
    chanBCapturePin <= v;
  endtask : set_capture
  always @(chanBOutPin) bChanges++;
endmodule : etco_pin_model

// ### dv/etco_timer_tb.sv
// Self-checking bench: registers, compare pins, clearing, modes, capture.
// Assumes etco_timer behind AXI4-Lite at 100 MHz and the pin model.
`timescale 1ns/1ns
module etco_timer_tb import etco_pkg::*; ;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, capPin, chanAOutPin, chanBOutPin;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rv;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rr;
  int miscompares = 0, num_checks = 0, bChanges;
  etco_timer #(.ADDR_WIDTH(8)) u_etco_timer (.ref_clk(ref_clk), .rst_n(rst_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .chanBCapturePin(capPin),
    .chanAOutPin(chanAOutPin), .chanBOutPin(chanBOutPin));
  etco_pin_model u_etco_pin_model (.chanBCapturePin(capPin),
    .chanBOutPin(chanBOutPin), .bChanges(bChanges));
  always #5 ref_clk = ~ref_clk;
  // --------------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && (pa || pw); n++) begin
      @(negedge ref_clk);
      pa = pa && !awready;
      pw = pw && !wready;
      @(posedge ref_clk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      pa = bvalid;
      rr = bresp;
      @(posedge ref_clk);
      if (pa) break;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      t = arready;
      @(posedge ref_clk);
      if (t) break;
    end
    arvalid <= 1'b0;
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      t = rvalid;
      rv = rdata[7:0];
      rr = rresp;
      @(posedge ref_clk);
      if (t) break;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask : rdchk
  task automatic pinchk(input int n, input logic e);
    repeat (n) @(negedge ref_clk);
    chk({7'h0, chanBOutPin}, {7'h0, e});
    @(posedge ref_clk);
  endtask : pinchk
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
    rdchk(OFF_CMPA_LO, 8'h00);
    rdchk(OFF_CMPB_HI, 8'h00);
    rdchk(OFF_CNT_HI, 8'h00);
    rdchk(OFF_CTRL2, CTRL2_RST);
    wr(OFF_CMPA_HI, 8'hff);
    rdchk(OFF_CMPA_HI, 8'h03);
    wr(OFF_CMPB_LO, 8'ha5);
    rdchk(OFF_CMPB_LO, 8'ha5);
    wstrb <= 4'he;
    wr(OFF_CMPB_LO, 8'h3c);
    wstrb <= 4'hf;
    rdchk(OFF_CMPB_LO, 8'ha5);
    wr(OFF_CNT_LO, 8'h5a);
    rdchk(OFF_CNT_LO, 8'h00);
    wr(8'hfc, 8'h01);
    chk({6'h0, rr}, {6'h0, RESP_SLVERR});
    rd(8'hfc);
    chk({6'h0, rr}, {6'h0, RESP_SLVERR});
    chk(rv, 8'h00);
    $display("regs test done");
  endtask : t_regs
  task automatic t_cmp(input logic lvl, input logic inv, input logic [1:0] func);
    logic post;
    int b0;
    post = func == FUNC_HOLD ? lvl : func == FUNC_LOW ? 1'b0 : func == FUNC_HIGH ? 1'b1 : !lvl;
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL2, {MODE_COMPARE, func, lvl, inv, ALIGN_EDGE});
    wr(OFF_CTRL0, 8'h08);
    pinchk(3, lvl ^ inv);
    b0 = bChanges;
    pinchk(20, post ^ inv);
    chk(8'(bChanges - b0), {7'h0, post != lvl});
    chk({7'h0, chanAOutPin}, 8'h00);
    $display("compare test done");
  endtask : t_cmp
  task automatic t_clr(input logic [7:0] c1, input logic [7:0] fl);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL1, c1);
    wr(OFF_FLAGS, 8'h07);
    wr(OFF_CTRL0, 8'h09);
    repeat (400) @(posedge ref_clk);
    rdchk(OFF_FLAGS, fl);
    rdchk(OFF_CNT_HI, 8'h00);
    $display("clear test done");
  endtask : t_clr
  task automatic t_mode(input logic [1:0] m, input logic [1:0] f, input logic e);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL1, {m, 6'h00});
    wr(OFF_CTRL2, {m, f, 2'h3, ALIGN_EDGE});
    wr(OFF_CTRL0, 8'h08);
    pinchk(4, e);
    $display("mode test done");
  endtask : t_mode
  task automatic t_cap(input logic [1:0] f);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL1, {MODE_CAPTURE, 6'h00});
    wr(OFF_CTRL2, {MODE_CAPTURE, f, 4'h0});
    wr(OFF_CTRL0, 8'h08);
    wr(OFF_FLAGS, 8'h07);
    u_etco_pin_model.set_capture(1'b1);
    repeat (8) @(posedge ref_clk);
    rd(OFF_FLAGS);
    chk(rv & 8'h02, (f == CAP_RISE || f == CAP_BOTH) ? 8'h02 : 8'h00);
    wr(OFF_FLAGS, 8'h07);
    u_etco_pin_model.set_capture(1'b0);
    repeat (8) @(posedge ref_clk);
    rd(OFF_FLAGS);
    chk(rv & 8'h02, (f == CAP_FALL || f == CAP_BOTH) ? 8'h02 : 8'h00);
    $display("capture test done");
  endtask : t_cap
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    wr(OFF_CMPB_LO, 8'h05);
    wr(OFF_CMPB_HI, 8'h00);
    t_cmp(1'b0, 1'b0, FUNC_HOLD);
    t_cmp(1'b0, 1'b0, FUNC_LOW);
    t_cmp(1'b0, 1'b0, FUNC_HIGH);
    t_cmp(1'b0, 1'b0, FUNC_TOGGLE);
    t_cmp(1'b1, 1'b0, FUNC_HIGH);
    t_cmp(1'b1, 1'b0, FUNC_LOW);
    t_cmp(1'b1, 1'b1, FUNC_TOGGLE);
    rd(OFF_FLAGS);
    chk(rv & 8'h02, 8'h02);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_FLAGS, 8'h02);
    rd(OFF_FLAGS);
    chk(rv & 8'h02, 8'h00);
    rd(OFF_CNT_LO);
    wdata <= {24'h0, rv};
    repeat (10) @(posedge ref_clk);
    rdchk(OFF_CNT_LO, wdata[7:0]);
    wr(OFF_CMPA_LO, 8'h14);
    wr(OFF_CMPA_HI, 8'h00);
    t_clr(8'h00, 8'h07);
    t_clr(8'h01, 8'h03);
    t_mode(MODE_PWM, FUNC_ACTIVE, 1'b0);
    t_mode(MODE_PWM, FUNC_INACTIVE, 1'b1);
    t_mode(MODE_PWM, FUNC_PWM, 1'b0);
    pinchk(4, 1'b1);
    t_mode(MODE_TIMER, FUNC_HIGH, 1'b0);
    for (int f = 0; f < 4; f++) t_cap(2'(f));
    results();
  end
endmodule : etco_timer_tb
